// [rtl/pmf_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module pmf_fifo #(
  parameter int WIDTH = pmf_pkg::DATA_W,
  parameter int DEPTH = pmf_pkg::DEPTH,
  parameter int CNT_W = pmf_pkg::CNT_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // control
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic pop_i,
  // data
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] head_o,
  // occupancy
  output logic [CNT_W-1:0] count_o,
  output logic [CNT_W-1:0] nxt_count_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [PTR_W-1:0] nxt_wr_ptr;
  logic [PTR_W-1:0] nxt_rd_ptr;
  logic [CNT_W-1:0] nxt_cnt;
  logic push_ok;
  logic pop_ok;

  // a push into a full queue is dropped, which is why writers watch full
  always_comb begin
    push_ok = push_i && (cnt_ff != CNT_W'(DEPTH)) && !clear_i;
    pop_ok = pop_i && (cnt_ff != '0) && !clear_i;
    nxt_wr_ptr = wr_ptr_ff + PTR_W'(push_ok);
    nxt_rd_ptr = rd_ptr_ff + PTR_W'(pop_ok);
    nxt_cnt = cnt_ff + CNT_W'(push_ok) - CNT_W'(pop_ok);
    if (clear_i) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_cnt = '0;
    end
  end

  // pointers and count
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset, contents only matter when counted
  always_ff @(posedge mclk_i) begin
    if (push_ok) begin
      mem[wr_ptr_ff] <= wdata_i;
    end
  end

  assign head_o = mem[rd_ptr_ff];
  assign count_o = cnt_ff;
  assign nxt_count_o = nxt_cnt;
endmodule : pmf_fifo
`default_nettype wire

// [rtl/pmf_pkg.sv]
// Function
// - master ready low in bus reset, clear
// - write enable low captures inbound data word
// - hold low postpones burst until release/full
// - write full flag when no free location
// - almost full when four or fewer free
// - write empty flag in pci clock domain
// - read enable low presents next read word
// - read data valid whenever queue not empty; the code loads data_to_user_o only on a read enable pop and holds it otherwise
// - read empty flag while read queue empty
package pmf_pkg;
  // queue geometry
  localparam int DATA_W = 64;
  localparam int DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] FULL_CNT = 6'h20;
  localparam logic [5:0] AFULL_FREE = 6'h04;
  localparam logic [5:0] AFULL_CNT = 6'h1C;
  localparam logic [5:0] EMPTY_CNT = 6'h00;

  // apb map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] CNT_OFF = 12'h008;

  // control register fields
  localparam int CTRL_BUS_RST_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_BUS_RST_RST = 1'b0;

  // status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_WFULL_BIT = 1;
  localparam int STAT_WAFULL_BIT = 2;
  localparam int STAT_WEMPTY_BIT = 3;
  localparam int STAT_REMPTY_BIT = 4;
  localparam int STAT_HOLD_BIT = 5;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_CMD_LSB = 12;
  localparam int CNT_RD_LSB = 16;

  // command bit that marks a write operation
  localparam int CMD_WRITE_BIT = 0;

  // synchronised pci-side inputs
  localparam int SYNC_W = 5;
  localparam int S_PCICLK = 0;
  localparam int S_HOLD = 1;
  localparam int S_WTAKE = 2;
  localparam int S_RPUSH = 3;
  localparam int S_PCIRST = 4;
  localparam logic [4:0] SYNC_RST = 5'h12;

  // flag values after reset
  localparam logic READY_RST = 1'b0;
  localparam logic FULL_N_RST = 1'b1;
  localparam logic AFULL_N_RST = 1'b1;
  localparam logic EMPTY_N_RST = 1'b0;

  // burst engine states
  typedef enum logic [2:0] {
    XF_IDLE = 3'b001,
    XF_HOLD = 3'b010,
    XF_BURST = 3'b100
  } pmf_xfer_e;
endpackage : pmf_pkg

// [rtl/pmf_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module pmf_sync #(
  parameter int W = pmf_pkg::SYNC_W,
  parameter logic [pmf_pkg::SYNC_W-1:0] RST_VAL = pmf_pkg::SYNC_RST
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // foreign inputs and their clean copies
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // a bit only changes once second and third stage agree
  always_comb begin
    nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));
  end

  // first stage feeds only the second
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      out_ff <= RST_VAL;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_o = out_ff;
endmodule : pmf_sync
`default_nettype wire

// [rtl/pmf_top.sv]
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module pmf_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pmf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // user side, queue clock
  input wire logic [3:0] mcmd_i,
  input wire logic [pmf_pkg::DATA_W-1:0] data_from_user_i,
  input wire logic wdata_en_n_i,
  input wire logic last_cyc_n_i,
  input wire logic rdata_en_n_i,
  input wire logic master_queues_clear_n_i,
  output logic [pmf_pkg::DATA_W-1:0] data_to_user_o,
  output logic master_ready_o,
  output logic write_fifo_full_n_o,
  output logic write_fifo_almost_full_n_o,
  output logic read_fifo_empty_n_o,
  // pci side, pci clock domain, sampled
  input wire logic pci_clk_i,
  input wire logic pci_rst_n_i,
  input wire logic bus_hold_n_i,
  input wire logic pci_wtake_i,
  input wire logic pci_rpush_i,
  input wire logic [pmf_pkg::DATA_W-1:0] pci_rdata_i,
  output logic write_fifo_empty_n_o,
  output logic [pmf_pkg::DATA_W-1:0] pci_wdata_o,
  output logic pci_wlast_o,
  output logic pci_wvalid_o,
  output logic pci_burst_o
);
  // register hit decode, shared by read and write paths
  function automatic logic reg_hit(input logic [pmf_pkg::ADDR_W-1:0] a,
                                   input logic [pmf_pkg::ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  logic [pmf_pkg::SYNC_W-1:0] pci_s;
  logic pci_clk_prev_ff;
  logic nxt_pci_clk_prev;
  logic pci_edge;
  logic hold_n_s;
  logic wtake_s;
  logic rpush_s;
  logic bus_reset;
  logic clear_all;

  // write queue carries the last strobe beside each word
  logic [pmf_pkg::DATA_W:0] w_head;
  logic [pmf_pkg::CNT_W-1:0] w_cnt;
  logic [pmf_pkg::CNT_W-1:0] w_nxt_cnt;
  logic w_push;
  logic w_pop;
  logic [pmf_pkg::DATA_W-1:0] r_head;
  logic [pmf_pkg::CNT_W-1:0] r_cnt;
  logic [pmf_pkg::CNT_W-1:0] r_nxt_cnt;
  logic r_push;
  logic r_pop;

  pmf_pkg::pmf_xfer_e state_ff;
  pmf_pkg::pmf_xfer_e nxt_state;
  logic [pmf_pkg::DATA_W-1:0] pci_wdata_ff;
  logic [pmf_pkg::DATA_W-1:0] nxt_pci_wdata;
  logic pci_wlast_ff;
  logic nxt_pci_wlast;
  logic pci_wvalid_ff;
  logic nxt_pci_wvalid;
  logic burst_ff;
  logic nxt_burst;

  logic ready_ff;
  logic nxt_ready;
  logic wfull_n_ff;
  logic nxt_wfull_n;
  logic wafull_n_ff;
  logic nxt_wafull_n;
  logic wempty_n_ff;
  logic nxt_wempty_n;
  logic rempty_n_ff;
  logic nxt_rempty_n;
  logic [pmf_pkg::DATA_W-1:0] rdata_ff;
  logic [pmf_pkg::DATA_W-1:0] nxt_rdata;
  logic [3:0] cmd_ff;
  logic [3:0] nxt_cmd;

  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic ctrl_bus_rst_ff;
  logic nxt_ctrl_bus_rst;
  logic soft_clear_ff;
  logic nxt_soft_clear;

  // pci-side levels cross through three stages and an output flop before use
  pmf_sync #(
    .W(pmf_pkg::SYNC_W),
    .RST_VAL(pmf_pkg::SYNC_RST)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({pci_rst_n_i, pci_rpush_i, pci_wtake_i, bus_hold_n_i, pci_clk_i}),
    .sync_o(pci_s)
  );

  // pci edge event from the cleaned pci clock copy
  always_comb begin
    nxt_pci_clk_prev = pci_s[pmf_pkg::S_PCICLK];
    pci_edge = pci_s[pmf_pkg::S_PCICLK] && !pci_clk_prev_ff;
    hold_n_s = pci_s[pmf_pkg::S_HOLD];
    wtake_s = pci_s[pmf_pkg::S_WTAKE];
    rpush_s = pci_s[pmf_pkg::S_RPUSH];
    bus_reset = ctrl_bus_rst_ff || !pci_s[pmf_pkg::S_PCIRST];
    clear_all = !master_queues_clear_n_i || soft_clear_ff || bus_reset;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pci_clk_prev_ff <= 1'b0;
    end else begin
      pci_clk_prev_ff <= nxt_pci_clk_prev;
    end
  end

  // queue strobes; rdata from the pci engine is held for a whole pci period
  always_comb begin
    w_push = !wdata_en_n_i;
    r_push = pci_edge && rpush_s;
    r_pop = !rdata_en_n_i && (r_cnt != pmf_pkg::EMPTY_CNT);
    w_pop = (state_ff == pmf_pkg::XF_BURST) && pci_edge && wtake_s &&
            (w_cnt != pmf_pkg::EMPTY_CNT);
  end

  pmf_fifo #(
    .WIDTH(pmf_pkg::DATA_W + 1),
    .DEPTH(pmf_pkg::DEPTH),
    .CNT_W(pmf_pkg::CNT_W)
  ) u_wfifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .clear_i(clear_all),
    .push_i(w_push),
    .pop_i(w_pop),
    .wdata_i({!last_cyc_n_i, data_from_user_i}),
    .head_o(w_head),
    .count_o(w_cnt),
    .nxt_count_o(w_nxt_cnt)
  );

  pmf_fifo #(
    .WIDTH(pmf_pkg::DATA_W),
    .DEPTH(pmf_pkg::DEPTH),
    .CNT_W(pmf_pkg::CNT_W)
  ) u_rfifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .clear_i(clear_all),
    .push_i(r_push),
    .pop_i(r_pop),
    .wdata_i(pci_rdata_i),
    .head_o(r_head),
    .count_o(r_cnt),
    .nxt_count_o(r_nxt_cnt)
  );

  // burst engine: waits in hold so the user can fill the queue first
  always_comb begin
    nxt_state = state_ff;
    nxt_pci_wdata = pci_wdata_ff;
    nxt_pci_wlast = pci_wlast_ff;
    nxt_pci_wvalid = w_pop;
    if (w_pop) begin
      nxt_pci_wdata = w_head[pmf_pkg::DATA_W-1:0];
      nxt_pci_wlast = w_head[pmf_pkg::DATA_W];
    end
    unique case (state_ff)
      pmf_pkg::XF_IDLE: begin
        if (pci_edge && cmd_ff[pmf_pkg::CMD_WRITE_BIT] &&
            (w_cnt != pmf_pkg::EMPTY_CNT)) begin
          nxt_state = pmf_pkg::XF_HOLD;
        end
      end
      pmf_pkg::XF_HOLD: begin
        if (pci_edge && (hold_n_s || (w_cnt == pmf_pkg::FULL_CNT))) begin
          nxt_state = pmf_pkg::XF_BURST;
        end
      end
      pmf_pkg::XF_BURST: begin
        if (w_pop && w_head[pmf_pkg::DATA_W]) begin
          nxt_state = pmf_pkg::XF_IDLE;
        end
      end
      default: begin
        nxt_state = pmf_pkg::XF_IDLE;
      end
    endcase
    if (clear_all) begin
      nxt_state = pmf_pkg::XF_IDLE;
    end
    nxt_burst = (nxt_state == pmf_pkg::XF_BURST);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= pmf_pkg::XF_IDLE;
      pci_wdata_ff <= '0;
      pci_wlast_ff <= 1'b0;
      pci_wvalid_ff <= 1'b0;
      burst_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pci_wdata_ff <= nxt_pci_wdata;
      pci_wlast_ff <= nxt_pci_wlast;
      pci_wvalid_ff <= nxt_pci_wvalid;
      burst_ff <= nxt_burst;
    end
  end

  // flags from next counts; all but write empty, which waits for a pci edge or clear, track the queue without lag
  always_comb begin
    nxt_ready = !bus_reset && !clear_all;
    nxt_wfull_n = (w_nxt_cnt != pmf_pkg::FULL_CNT);
    nxt_wafull_n = (w_nxt_cnt < pmf_pkg::AFULL_CNT);
    nxt_rempty_n = (r_nxt_cnt != pmf_pkg::EMPTY_CNT);
    nxt_wempty_n = wempty_n_ff;
    if (pci_edge || clear_all) begin
      nxt_wempty_n = (w_nxt_cnt != pmf_pkg::EMPTY_CNT);
    end
    nxt_rdata = r_pop ? r_head : rdata_ff;
    nxt_cmd = mcmd_i;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_ff <= pmf_pkg::READY_RST;
      wfull_n_ff <= pmf_pkg::FULL_N_RST;
      wafull_n_ff <= pmf_pkg::AFULL_N_RST;
      rempty_n_ff <= pmf_pkg::EMPTY_N_RST;
      wempty_n_ff <= pmf_pkg::EMPTY_N_RST;
      rdata_ff <= '0;
      cmd_ff <= '0;
    end else begin
      ready_ff <= nxt_ready;
      wfull_n_ff <= nxt_wfull_n;
      wafull_n_ff <= nxt_wafull_n;
      rempty_n_ff <= nxt_rempty_n;
      wempty_n_ff <= nxt_wempty_n;
      rdata_ff <= nxt_rdata;
      cmd_ff <= nxt_cmd;
    end
  end

  // apb slave, one wait state so read data comes from a flop
  always_comb begin
    nxt_pready = psel_i && penable_i && !pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = '0;
    nxt_ctrl_bus_rst = ctrl_bus_rst_ff;
    nxt_soft_clear = 1'b0;
    if (nxt_pready) begin
      if (reg_hit(paddr_i, pmf_pkg::CTRL_OFF)) begin
        nxt_prdata[pmf_pkg::CTRL_BUS_RST_BIT] = ctrl_bus_rst_ff;
        if (pwrite_i) begin
          nxt_ctrl_bus_rst = pwdata_i[pmf_pkg::CTRL_BUS_RST_BIT];
          nxt_soft_clear = pwdata_i[pmf_pkg::CTRL_CLEAR_BIT];
        end
      end else if (reg_hit(paddr_i, pmf_pkg::STAT_OFF)) begin
        nxt_prdata[pmf_pkg::STAT_READY_BIT] = ready_ff;
        nxt_prdata[pmf_pkg::STAT_WFULL_BIT] = wfull_n_ff;
        nxt_prdata[pmf_pkg::STAT_WAFULL_BIT] = wafull_n_ff;
        nxt_prdata[pmf_pkg::STAT_WEMPTY_BIT] = wempty_n_ff;
        nxt_prdata[pmf_pkg::STAT_REMPTY_BIT] = rempty_n_ff;
        nxt_prdata[pmf_pkg::STAT_HOLD_BIT] = hold_n_s;
        nxt_prdata[pmf_pkg::STAT_STATE_LSB +: 3] = state_ff;
        nxt_prdata[pmf_pkg::STAT_CMD_LSB +: 4] = cmd_ff;
      end else if (reg_hit(paddr_i, pmf_pkg::CNT_OFF)) begin
        nxt_prdata[pmf_pkg::CNT_W-1:0] = w_cnt;
        nxt_prdata[pmf_pkg::CNT_RD_LSB +: pmf_pkg::CNT_W] = r_cnt;
      end else begin
        nxt_pslverr = 1'b1; // unmapped: error, reads zero
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      ctrl_bus_rst_ff <= pmf_pkg::CTRL_BUS_RST_RST;
      soft_clear_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      ctrl_bus_rst_ff <= nxt_ctrl_bus_rst;
      soft_clear_ff <= nxt_soft_clear;
    end
  end

  // outputs, each straight from a flop
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign data_to_user_o = rdata_ff;
  assign master_ready_o = ready_ff;
  assign write_fifo_full_n_o = wfull_n_ff;
  assign write_fifo_almost_full_n_o = wafull_n_ff;
  assign read_fifo_empty_n_o = rempty_n_ff;
  assign write_fifo_empty_n_o = wempty_n_ff;
  assign pci_wdata_o = pci_wdata_ff;
  assign pci_wlast_o = pci_wlast_ff;
  assign pci_wvalid_o = pci_wvalid_ff;
  assign pci_burst_o = burst_ff;
endmodule : pmf_top
`default_nettype wire

// [verification/pci_master_fifo_interface_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pci_master_fifo_interface_tb;
  logic mclk_i, reset_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic wr_en_n = 1'b1, last_n = 1'b1, rd_en_n = 1'b1, clr_n = 1'b1;
  logic hold_req = 1'b0, slow = 1'b0, bus_rst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q, prdata;
  logic [3:0] mcmd = 4'h0, push_num = 4'h0;
  logic [63:0] din = 64'h0000_0000_0000_0000, dout, wdata, rdata;
  logic pready, pslverr, ready, full_n, afull_n, rempty_n, wempty_n, wlast, wvalid, burst;
  logic pclk, prst_n, hold_n, wtake, rpush;
  logic [64:0] got[$];
  int failures = 0, checked = 0, cyc = 0;
  pmf_top pmf_top_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .mcmd_i(mcmd), .data_from_user_i(din), .wdata_en_n_i(wr_en_n),
    .last_cyc_n_i(last_n), .rdata_en_n_i(rd_en_n), .master_queues_clear_n_i(clr_n),
    .data_to_user_o(dout), .master_ready_o(ready), .write_fifo_full_n_o(full_n),
    .write_fifo_almost_full_n_o(afull_n), .read_fifo_empty_n_o(rempty_n), .pci_clk_i(pclk),
    .pci_rst_n_i(prst_n), .bus_hold_n_i(hold_n), .pci_wtake_i(wtake), .pci_rpush_i(rpush),
    .pci_rdata_i(rdata), .write_fifo_empty_n_o(wempty_n), .pci_wdata_o(wdata),
    .pci_wlast_o(wlast), .pci_wvalid_o(wvalid), .pci_burst_o(burst));
  pmf_pci_model pmf_pci_model_i (.hold_req_i(hold_req), .slow_i(slow), .bus_rst_i(bus_rst),
    .push_num_i(push_num), .pci_clk_o(pclk), .pci_rst_n_o(prst_n), .bus_hold_n_o(hold_n),
    .pci_wtake_o(wtake), .pci_rpush_o(rpush), .pci_rdata_o(rdata));
  // queue clock and a hang guard sized well past the whole sequence
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // collect every word handed to the pci side
  always @(posedge mclk_i) begin
    if (wvalid === 1'b1) got.push_back({wlast, wdata});
  end
  task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // one apb transfer; waits for pready, bounded by the hang guard
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // back-to-back pushes, last strobe on word index lst
  task automatic push(input int n, input int base, input int lst);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      wr_en_n <= 1'b0;
      din <= {32'h5A5A_0000, base + i};
      last_n <= (i != lst);
    end
    @(posedge mclk_i);
    wr_en_n <= 1'b1;
    last_n <= 1'b1;
  endtask : push
  task automatic pop(input logic [63:0] e);
    @(posedge mclk_i);
    rd_en_n <= 1'b0;
    @(posedge mclk_i);
    rd_en_n <= 1'b1;
    @(negedge mclk_i);
    chk(dout, e);
  endtask : pop
  task automatic wait_ready;
    for (int n = 0; n < 100 && ready !== 1'b1; n++) @(posedge mclk_i);
    chk(ready, 1'b1);
  endtask : wait_ready
  // main sequence
  initial begin
    int n;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wait_ready();
    apb(1'b0, pmf_pkg::STAT_OFF, 32'h0000_0000);
    chk(q, 32'h0000_0127);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(err, 1'b1);
    // fill with engine parked and the far side holding and stalling
    hold_req <= 1'b1;
    slow <= 1'b1;
    push(27, 0, 99);
    @(negedge mclk_i) chk(afull_n, 1'b1);
    push(1, 27, 99);
    @(negedge mclk_i) chk(afull_n, 1'b0);
    chk(full_n, 1'b1);
    push(4, 28, 3);
    @(negedge mclk_i) chk(full_n, 1'b0);
    push(1, 40, 99);
    apb(1'b0, pmf_pkg::CNT_OFF, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    for (n = 0; n < 200 && wempty_n !== 1'b1; n++) @(posedge mclk_i);
    chk(wempty_n, 1'b1);
    mcmd <= 4'h1;
    for (n = 0; n < 2000 && got.size() < 32; n++) @(posedge mclk_i);
    for (n = 0; n < 32; n++) chk(got[n], {n == 31, 32'h5A5A_0000, n});
    got.delete();
    for (n = 0; n < 300 && wempty_n !== 1'b0; n++) @(posedge mclk_i);
    chk(wempty_n, 1'b0);
    // a short burst waits until the hold is let go
    slow <= 1'b0;
    push(2, 100, 1);
    repeat (80) @(posedge mclk_i);
    chk(burst, 1'b0);
    hold_req <= 1'b0;
    for (n = 0; n < 300 && got.size() < 2; n++) @(posedge mclk_i);
    chk(got[0], {1'b0, 32'h5A5A_0000, 32'd100});
    chk(got[1], {1'b1, 32'h5A5A_0000, 32'd101});
    // read words arrive from the pci side; a pop on empty holds the data
    hold_req <= 1'b1;
    push_num <= 4'h3;
    for (n = 0; n < 300 && rempty_n !== 1'b1; n++) @(posedge mclk_i);
    chk(rempty_n, 1'b1);
    repeat (60) @(posedge mclk_i);
    for (n = 0; n < 4; n++) pop(64'h7E57_0000_0000_0000 + 64'(n < 3 ? n : 2));
    chk(rempty_n, 1'b0);
    // clear pin empties both queues and drops ready for its cycle
    push_num <= 4'h5;
    push(1, 200, 0);
    repeat (60) @(posedge mclk_i);
    clr_n <= 1'b0;
    @(posedge mclk_i);
    clr_n <= 1'b1;
    @(negedge mclk_i) chk(ready, 1'b0);
    chk(rempty_n, 1'b0);
    apb(1'b0, pmf_pkg::CNT_OFF, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wait_ready();
    apb(1'b0, pmf_pkg::STAT_OFF, 32'h0000_0000);
    chk(q[15:12], 4'h1);
    // register clear bit empties the write queue too
    push(1, 300, 0);
    apb(1'b1, pmf_pkg::CTRL_OFF, 32'h0000_0002);
    apb(1'b0, pmf_pkg::CNT_OFF, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // pci bus reset withdraws ready
    bus_rst <= 1'b1;
    for (n = 0; n < 100 && ready !== 1'b0; n++) @(posedge mclk_i);
    chk(ready, 1'b0);
    bus_rst <= 1'b0;
    wait_ready();
    // register bus reset bit withdraws ready as the pin does
    apb(1'b1, pmf_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b0, pmf_pkg::CTRL_OFF, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    chk(ready, 1'b0);
    apb(1'b1, pmf_pkg::CTRL_OFF, 32'h0000_0000);
    wait_ready();
    tally_and_finish();
  end
endmodule : pci_master_fifo_interface_tb
`default_nettype wire

// [verification/pmf_pci_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pmf_pci_model (
  // requests from the bench
  input wire logic hold_req_i,
  input wire logic slow_i,
  input wire logic bus_rst_i,
  input wire logic [3:0] push_num_i,
  // pci-side stand-ins
  output logic pci_clk_o,
  output logic pci_rst_n_o,
  output logic bus_hold_n_o,
  output logic pci_wtake_o,
  output logic pci_rpush_o,
  output logic [63:0] pci_rdata_o
);
  logic [1:0] lo_cnt = 2'h0;
  logic [3:0] pushed = 4'h0;
  logic tog = 1'b0;
  // far-side lines start idle, each driven from one process only
  logic hold_n_q = 1'b1;
  logic take_q = 1'b0;
  logic rpush_q = 1'b0;
  logic [63:0] rdata_q = 64'h0000_0000_0000_0000;
  assign bus_hold_n_o = hold_n_q;
  assign pci_wtake_o = take_q;
  assign pci_rpush_o = rpush_q;
  assign pci_rdata_o = rdata_q;
  // pci clock runs free, ten queue clocks a period
  initial begin
    pci_clk_o = 1'b0;
    forever #40 pci_clk_o = ~pci_clk_o;
  end
  assign pci_rst_n_o = !bus_rst_i;
  // all far-side lines but pci reset move just after a pci rising edge
  always @(posedge pci_clk_o) begin
    tog <= ~tog;
    take_q <= !slow_i || tog; // slow mode stalls every other period
    if (!hold_n_q && lo_cnt != 2'h2) begin
      lo_cnt <= lo_cnt + 2'h1;
    end else begin
      lo_cnt <= 2'h0;
      hold_n_q <= !hold_req_i;
    end
    rpush_q <= pushed < push_num_i;
    if (pushed < push_num_i) begin
      pushed <= pushed + 4'h1;
      rdata_q <= 64'h7E57_0000_0000_0000 + {60'h0, pushed};
    end else begin
      rdata_q <= ~rdata_q; // idle bus shows no stale word
    end
  end
endmodule : pmf_pci_model
`default_nettype wire

// [verification/pmf_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pmf_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // apb handshake
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  // user side
  input wire logic wdata_en_n_i,
  input wire logic rdata_en_n_i,
  input wire logic master_queues_clear_n_i,
  input wire logic [pmf_pkg::DATA_W-1:0] data_to_user_o,
  input wire logic master_ready_o,
  input wire logic write_fifo_full_n_o,
  input wire logic write_fifo_almost_full_n_o,
  input wire logic read_fifo_empty_n_o,
  // pci side
  input wire logic bus_hold_n_i,
  input wire logic pci_wvalid_o,
  input wire logic pci_burst_o
);
  // cycles the hold request stayed low, saturating so it never wraps
  logic [3:0] hold_lo_ff;
  logic [3:0] nxt_hold_lo;
  always_comb begin
    nxt_hold_lo = bus_hold_n_i ? 4'h0 : hold_lo_ff + {3'h0, hold_lo_ff != 4'hF};
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_lo_ff <= 4'h0;
    end else begin
      hold_lo_ff <= nxt_hold_lo;
    end
  end
  // one clock domain only
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_access; psel_i && penable_i && !pready_o; endsequence
  sequence s_clear; !master_queues_clear_n_i; endsequence
  sequence s_quiet;
    rdata_en_n_i && master_queues_clear_n_i && master_ready_o && !psel_i;
  endsequence
  property p_pready; s_access |=> pready_o; endproperty
  property p_pulse; pready_o |=> !pready_o; endproperty
  property p_ready_clr; s_clear |=> !master_ready_o; endproperty
  property p_clr_flags; s_clear |=> !read_fifo_empty_n_o && write_fifo_full_n_o; endproperty
  property p_full_step; !wdata_en_n_i && write_fifo_almost_full_n_o |=> write_fifo_full_n_o;
  endproperty
  property p_afull; !write_fifo_full_n_o |-> !write_fifo_almost_full_n_o; endproperty
  property p_hold_data; s_quiet |=> $stable(data_to_user_o); endproperty
  property p_wvalid; pci_wvalid_o |-> pci_burst_o || $past(pci_burst_o); endproperty
  // a long hold with room left must not start a burst
  property p_hold; hold_lo_ff == 4'hF && write_fifo_full_n_o |-> !$rose(pci_burst_o);
  endproperty
  a_pready: assert property (p_pready) else $error("apb access not answered");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_ready_clr: assert property (p_ready_clr) else $error("ready high after clear");
  a_clr_flags: assert property (p_clr_flags) else $error("flags wrong after clear");
  a_full_step: assert property (p_full_step) else $error("full too early");
  a_afull: assert property (p_afull) else $error("full without almost full");
  a_hold_data: assert property (p_hold_data) else $error("read data moved");
  a_wvalid: assert property (p_wvalid) else $error("word sent outside burst");
  a_hold: assert property (p_hold) else $error("burst began during hold");
endmodule : pmf_sva
bind pmf_top pmf_sva pmf_sva_i (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .wdata_en_n_i(wdata_en_n_i), .rdata_en_n_i(rdata_en_n_i),
  .master_queues_clear_n_i(master_queues_clear_n_i), .data_to_user_o(data_to_user_o),
  .master_ready_o(master_ready_o), .write_fifo_full_n_o(write_fifo_full_n_o),
  .write_fifo_almost_full_n_o(write_fifo_almost_full_n_o),
  .read_fifo_empty_n_o(read_fifo_empty_n_o), .bus_hold_n_i(bus_hold_n_i),
  .pci_wvalid_o(pci_wvalid_o), .pci_burst_o(pci_burst_o)
);
`default_nettype wire
